// file: src/sbalc_pkg.sv
/*
 Constants for the serial bus access and line coding block.
 Assumes one 20 MHz system clock and an APB register port.
*/
package sbalc_pkg;
	localparam logic [7:0] ADDR_CFG = 8'h00;
	localparam logic [7:0] ADDR_DIV = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam int CFG_MODE = 0;
	localparam int CFG_CODE = 2;
	localparam int CFG_BUS = 5;
	localparam int CFG_TS = 6;
	localparam int CFG_INV = 8;
	localparam int CFG_RTSB = 9;
	localparam int CFG_CLKM = 10;
	localparam int CFG_SYNCEN = 13;
	localparam int CFG_W = 14;
	localparam logic [13:0] CFG_RST = 14'h0000;
	localparam logic [15:0] DIV_RST = 16'h0004;
	localparam logic [1:0] MODE_HDLC = 2'h0;
	localparam logic [1:0] MODE_BISYNC = 2'h1;
	localparam logic [2:0] CODE_NRZ = 3'h0;
	localparam logic [2:0] CODE_NRZI = 3'h1;
	localparam logic [2:0] CODE_FM0 = 3'h2;
	localparam logic [2:0] CODE_FM1 = 3'h3;
	localparam logic [2:0] CODE_MAN = 3'h4;
	localparam logic [1:0] TS_MODE1 = 2'h1;
	localparam logic [1:0] TS_MODE2 = 2'h3;
	localparam logic [3:0] IDLE_ONES = 4'h8;
	localparam logic [3:0] LOW_ONES = 4'hA;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} sbalc_state_t;
endpackage : sbalc_pkg

// file: src/sbalc_top.sv
/*
 Serial bus access, collision handling and line coding for one channel.
 Assumes a bit source that holds the current bit while tx_req_in is high,
 and a wired-OR bus returned on collision_sense_in.
*/
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sbalc_top (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// APB
	input wire logic [7:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Bit source from the transmit queue
	input wire logic tx_req_in,
	input wire logic tx_bit_in,
	input wire logic tx_last_in,
	input wire logic frame_start_held_in,
	output logic tx_take_out,
	output logic tx_retry_out,
	output logic queue_reset_out,
	output logic message_repeat_irq_out,
	// Line pins
	input wire logic collision_sense_in,
	input wire logic rx_line_in,
	output logic txd_out,
	output logic txd_oe_n_out,
	output logic rts_n_out,
	// Receive side
	output logic rx_bit_out,
	output logic rx_valid_out,
	output logic dpll_sync_out,
	output logic dpll_irq_out
);
	////////////////////////////////////////////////////////////////////
	// Line coding functions
	function automatic logic enc_first(input logic [2:0] code,
		input logic b, input logic prev, input logic inv);
		if (code == sbalc_pkg::CODE_NRZ) begin
			enc_first = b ^ inv;
		end else if (code == sbalc_pkg::CODE_NRZI) begin
			enc_first = b ? prev : ~prev;
		end else if (code == sbalc_pkg::CODE_MAN) begin
			enc_first = b;
		end else begin
			enc_first = ~prev;
		end
	endfunction : enc_first
	function automatic logic enc_second(input logic [2:0] code,
		input logic b, input logic cur);
		if (code == sbalc_pkg::CODE_FM0) begin
			enc_second = b ? cur : ~cur;
		end else if (code == sbalc_pkg::CODE_FM1) begin
			enc_second = b ? ~cur : cur;
		end else if (code == sbalc_pkg::CODE_MAN) begin
			enc_second = ~cur;
		end else begin
			enc_second = cur;
		end
	endfunction : enc_second
	////////////////////////////////////////////////////////////////////
	// Registers and fields
	logic [13:0] cfg;
	logic [15:0] div;
	logic [1:0] mode;
	logic [2:0] code;
	logic [1:0] ts;
	logic [2:0] clkm;
	logic bus_en, inv, rts_bus, sync_en, biphase;
	assign mode = cfg[sbalc_pkg::CFG_MODE +: 2];
	assign code = cfg[sbalc_pkg::CFG_CODE +: 3];
	assign bus_en = cfg[sbalc_pkg::CFG_BUS];
	assign ts = cfg[sbalc_pkg::CFG_TS +: 2];
	assign inv = cfg[sbalc_pkg::CFG_INV];
	assign rts_bus = cfg[sbalc_pkg::CFG_RTSB];
	assign clkm = cfg[sbalc_pkg::CFG_CLKM +: 3];
	assign sync_en = cfg[sbalc_pkg::CFG_SYNCEN];
	assign biphase = (code == sbalc_pkg::CODE_FM0) ||
		(code == sbalc_pkg::CODE_FM1) || (code == sbalc_pkg::CODE_MAN);
	sbalc_pkg::sbalc_state_t state;
	logic [3:0] ones_cnt;
	logic prio_low, done_ok, pending, ok_bit, cur_bit, cur_last;
	logic cxd_meta, cxd_s, rxd_meta, rxd_s;
	logic [15:0] div_cnt;
	logic half, tick, rise_tick, fall_tick, drive_tick;
	logic start_ok, collide, h1, rx_prev, next_sync;
	logic apb_wr;
	////////////////////////////////////////////////////////////////////
	// APB slave, answers in the first access cycle
	assign apb_wr = psel_in && penable_in && pready_out && pwrite_in;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= psel_in && !penable_in;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			if (psel_in && !penable_in) begin
				if (paddr_in == sbalc_pkg::ADDR_CFG) begin
					prdata_out <= {18'h0_0000, cfg};
				end else if (paddr_in == sbalc_pkg::ADDR_DIV) begin
					prdata_out <= {16'h0000, div};
				end else if (paddr_in == sbalc_pkg::ADDR_STAT) begin
					prdata_out <= {24'h00_0000, ones_cnt, prio_low,
						(state == sbalc_pkg::ST_SEND), dpll_sync_out,
						(ones_cnt >= sbalc_pkg::IDLE_ONES)};
				end else begin
					pslverr_out <= 1'b1;
				end
			end
		end
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cfg <= sbalc_pkg::CFG_RST;
			div <= sbalc_pkg::DIV_RST;
		end else if (apb_wr) begin
			if (paddr_in == sbalc_pkg::ADDR_CFG) begin
				cfg <= pwdata_in[13:0];
			end else if (paddr_in == sbalc_pkg::ADDR_DIV) begin
				div <= pwdata_in[15:0];
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cxd_meta <= 1'b1;
			cxd_s <= 1'b1;
			rxd_meta <= 1'b1;
			rxd_s <= 1'b1;
		end else begin
			cxd_meta <= collision_sense_in;
			cxd_s <= cxd_meta;
			rxd_meta <= rx_line_in;
			rxd_s <= rxd_meta;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Transmit clock as half period enables
	assign tick = (div_cnt == 16'h0000);
	assign rise_tick = tick && !half;
	assign fall_tick = tick && half;
	assign drive_tick = (bus_en && ts == sbalc_pkg::TS_MODE2) ?
		fall_tick : rise_tick;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_cnt <= 16'h0000;
			half <= 1'b0;
		end else if (tick) begin
			div_cnt <= (div > 16'h0001) ? div - 16'h0001 : 16'h0000;
			half <= !half;
		end else begin
			div_cnt <= div_cnt - 16'h0001;
		end
	end
	////////////////////////////////////////////////////////////////////
	// Bus idle detection and priority class
	assign start_ok = !bus_en || (ones_cnt >= (prio_low ?
		sbalc_pkg::LOW_ONES : sbalc_pkg::IDLE_ONES));
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ones_cnt <= 4'h0;
			prio_low <= 1'b0;
		end else if (done_ok && bus_en && mode == sbalc_pkg::MODE_HDLC) begin
			prio_low <= 1'b1;
			ones_cnt <= 4'h0;
		end else begin
			if (fall_tick) begin
				if (!cxd_s) begin
					ones_cnt <= 4'h0;
				end else if (ones_cnt != sbalc_pkg::LOW_ONES) begin
					ones_cnt <= ones_cnt + 4'h1;
				end
			end
			if (prio_low && ones_cnt == sbalc_pkg::LOW_ONES) begin
				prio_low <= 1'b0;
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// Transmitter with collision detection
	assign collide = fall_tick && pending && bus_en &&
		(txd_out != cxd_s);
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= sbalc_pkg::ST_IDLE;
			txd_out <= 1'b1;
			txd_oe_n_out <= 1'b1;
			cur_bit <= 1'b1;
			cur_last <= 1'b0;
			pending <= 1'b0;
			ok_bit <= 1'b0;
			done_ok <= 1'b0;
			tx_take_out <= 1'b0;
			tx_retry_out <= 1'b0;
			queue_reset_out <= 1'b0;
			message_repeat_irq_out <= 1'b0;
		end else begin
			tx_take_out <= 1'b0;
			tx_retry_out <= 1'b0;
			queue_reset_out <= 1'b0;
			message_repeat_irq_out <= 1'b0;
			done_ok <= 1'b0;
			case (state)
				sbalc_pkg::ST_IDLE: begin
					ok_bit <= 1'b0;
					pending <= 1'b0;
					if (drive_tick && tx_req_in && start_ok) begin
						state <= sbalc_pkg::ST_SEND;
						cur_bit <= tx_bit_in;
						cur_last <= tx_last_in;
						tx_take_out <= 1'b1;
						pending <= 1'b1;
						txd_out <= enc_first(code, tx_bit_in, txd_out, inv);
						txd_oe_n_out <= enc_first(code, tx_bit_in, txd_out, inv);
					end else if (drive_tick) begin
						txd_out <= 1'b1;
						txd_oe_n_out <= 1'b1;
					end
				end
				sbalc_pkg::ST_SEND: begin
					if (collide) begin
						state <= sbalc_pkg::ST_IDLE;
						txd_out <= 1'b1;
						txd_oe_n_out <= 1'b1;
						pending <= 1'b0;
						ok_bit <= 1'b0;
						if (mode == sbalc_pkg::MODE_HDLC) begin
							tx_retry_out <= frame_start_held_in;
							message_repeat_irq_out <= !frame_start_held_in;
						end else if (mode == sbalc_pkg::MODE_BISYNC) begin
							queue_reset_out <= 1'b1;
							message_repeat_irq_out <= 1'b1;
						end
					end else begin
						if (fall_tick && pending) begin
							pending <= 1'b0;
							ok_bit <= 1'b1;
						end
						if (drive_tick && (cur_last || !tx_req_in)) begin
							state <= sbalc_pkg::ST_IDLE;
							done_ok <= cur_last;
							txd_out <= 1'b1;
							txd_oe_n_out <= 1'b1;
						end else if (drive_tick) begin
							cur_bit <= tx_bit_in;
							cur_last <= tx_last_in;
							tx_take_out <= 1'b1;
							pending <= 1'b1;
							txd_out <= enc_first(code, tx_bit_in, txd_out, inv);
							txd_oe_n_out <= enc_first(code, tx_bit_in, txd_out,
								inv);
						end else if (fall_tick && biphase) begin
							txd_out <= enc_second(code, cur_bit, txd_out);
							txd_oe_n_out <= enc_second(code, cur_bit, txd_out);
						end
					end
				end
				default: begin
					state <= sbalc_pkg::ST_IDLE;
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////
	// Request to send
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rts_n_out <= 1'b1;
		end else if (!(bus_en && rts_bus && (clkm == 3'h0 ||
			clkm == 3'h1 || clkm == 3'h4))) begin
			rts_n_out <= (state != sbalc_pkg::ST_SEND);
		end else if (drive_tick) begin
			rts_n_out <= !(state == sbalc_pkg::ST_SEND && (ok_bit ||
				(fall_tick && pending && !collide)));
		end
	end
	////////////////////////////////////////////////////////////////////
	// Receive decoding and bi-phase sync supervision
	always_comb begin
		if (code == sbalc_pkg::CODE_MAN) begin
			next_sync = (h1 != rxd_s);
		end else begin
			next_sync = (h1 != rx_prev);
		end
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			h1 <= 1'b1;
			rx_prev <= 1'b1;
			rx_bit_out <= 1'b1;
			rx_valid_out <= 1'b0;
			dpll_sync_out <= 1'b0;
			dpll_irq_out <= 1'b0;
		end else begin
			rx_valid_out <= 1'b0;
			dpll_irq_out <= 1'b0;
			if (!biphase) begin
				dpll_sync_out <= 1'b0;
			end
			if (fall_tick) begin
				h1 <= rxd_s;
			end
			if (fall_tick && !biphase) begin
				rx_valid_out <= 1'b1;
				rx_prev <= rxd_s;
				if (code == sbalc_pkg::CODE_NRZI) begin
					rx_bit_out <= (rxd_s == rx_prev);
				end else begin
					rx_bit_out <= rxd_s ^ inv;
				end
			end
			if (rise_tick && biphase) begin
				rx_valid_out <= 1'b1;
				rx_prev <= rxd_s;
				if (code == sbalc_pkg::CODE_FM0) begin
					rx_bit_out <= (h1 == rxd_s);
				end else if (code == sbalc_pkg::CODE_FM1) begin
					rx_bit_out <= (h1 != rxd_s);
				end else begin
					rx_bit_out <= h1;
				end
				dpll_sync_out <= next_sync;
				dpll_irq_out <= sync_en && (next_sync != dpll_sync_out);
			end
		end
	end
	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);
	chk_idle_drives_one: assert property (
		state == sbalc_pkg::ST_IDLE && drive_tick && !(tx_req_in && start_ok)
		|=> txd_out && txd_oe_n_out)
		else $error("Idle line not driven high");
	chk_ones_count_up: assert property (
		fall_tick && cxd_s && ones_cnt < sbalc_pkg::LOW_ONES && !done_ok
		|=> ones_cnt == $past(ones_cnt) + 4'h1)
		else $error("Ones counter did not advance");
	chk_zero_marks_busy: assert property (
		fall_tick && !cxd_s |=> ones_cnt == 4'h0)
		else $error("Zero on bus did not mark busy");
	chk_collision_aborts: assert property (
		state == sbalc_pkg::ST_SEND && collide
		|=> state == sbalc_pkg::ST_IDLE && txd_out)
		else $error("Collision did not abort");
	chk_hdlc_retry: assert property (
		state == sbalc_pkg::ST_SEND && collide &&
		mode == sbalc_pkg::MODE_HDLC
		|=> tx_retry_out == $past(frame_start_held_in) &&
		message_repeat_irq_out == !$past(frame_start_held_in))
		else $error("HDLC collision outcome wrong");
	chk_bisync_reset: assert property (
		state == sbalc_pkg::ST_SEND && collide &&
		mode == sbalc_pkg::MODE_BISYNC
		|=> queue_reset_out && message_repeat_irq_out && txd_out)
		else $error("BISYNC collision outcome wrong");
	chk_class_lowered: assert property (
		done_ok && bus_en && mode == sbalc_pkg::MODE_HDLC
		|=> prio_low && ones_cnt == 4'h0)
		else $error("Class not lowered after frame");
	chk_class_restored: assert property (
		prio_low && ones_cnt == sbalc_pkg::LOW_ONES && !done_ok
		|=> !prio_low)
		else $error("Class not restored after ten ones");
	chk_rise_drive: assert property (
		bus_en && ts == sbalc_pkg::TS_MODE1 &&
		state == sbalc_pkg::ST_SEND && $past(state) == sbalc_pkg::ST_SEND &&
		$changed(txd_out) |-> $past(rise_tick))
		else $error("Mode 01 bit not driven on rise");
	chk_fall_drive: assert property (
		bus_en && ts == sbalc_pkg::TS_MODE2 &&
		state == sbalc_pkg::ST_SEND && $past(state) == sbalc_pkg::ST_SEND &&
		$changed(txd_out) |-> $past(fall_tick))
		else $error("Mode 11 bit not driven on fall");
	chk_sync_flag: assert property (
		rise_tick && biphase |=> dpll_sync_out == $past(next_sync))
		else $error("Sync flag not updated");
	cov_frame_start: cover property (state == sbalc_pkg::ST_IDLE ##1
		state == sbalc_pkg::ST_SEND);
	cov_collision: cover property (state == sbalc_pkg::ST_SEND && collide);
	cov_frame_done: cover property (done_ok && prio_low == 1'b0);
	cov_sync_irq: cover property (dpll_irq_out);
endmodule : sbalc_top
`default_nettype wire

// file: tb/sbalc_bus_model.sv
/*
 Other stations on the shared serial bus, as one open-drain driver.
 Assumes a pull-up on the bus line and a local pin driven open drain.
*/
`timescale 1ns/1ps
`default_nettype none
module sbalc_bus_model (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Local pin and command
	input wire logic txd_oe_n_in,
	input wire logic jam_in,
	// Bus level
	output logic bus_out
);
	logic jam;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in)
			jam <= 1'b0;
		else
			jam <= jam_in;
	end
	// Any low driver wins, pull-up gives one, fed back to all
	assign bus_out = ~(~txd_oe_n_in | jam);
endmodule : sbalc_bus_model
`default_nettype wire

// file: tb/sbalc_top_tb_top.sv
/*
 Self-checking bench for the bus access and line coding block.
 Assumes the package constants and a DIV reset value of 4.
*/
`timescale 1ns/1ps
`default_nettype none
module sbalc_top_tb_top;
	logic clock_in = 1'b0;
	logic rst_n_in, psel, penable, pwrite, req, tbit, last, held, jam;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, take, retry, qrst, mrep, txd, oe_n, rts_n;
	logic rxb, rxv, sync, dirq, bus, er;
	logic saw_irq = 1'b0;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	sbalc_top sbalc_top_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.paddr_in(paddr), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .tx_req_in(req),
		.tx_bit_in(tbit), .tx_last_in(last), .frame_start_held_in(held),
		.tx_take_out(take), .tx_retry_out(retry), .queue_reset_out(qrst),
		.message_repeat_irq_out(mrep), .collision_sense_in(bus),
		.rx_line_in(bus), .txd_out(txd), .txd_oe_n_out(oe_n),
		.rts_n_out(rts_n), .rx_bit_out(rxb), .rx_valid_out(rxv),
		.dpll_sync_out(sync), .dpll_irq_out(dirq));
	sbalc_bus_model sbalc_bus_model_inst (.clock_in(clock_in),
		.rst_n_in(rst_n_in), .txd_oe_n_in(oe_n), .jam_in(jam),
		.bus_out(bus));

	initial begin
		forever #25 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (dirq === 1'b1)
			saw_irq <= 1'b1;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock_in);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		do begin
			@(posedge clock_in);
			k++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] cfgv(input logic [1:0] m,
		input logic [2:0] c, input logic b, input logic [1:0] ts,
		input logic inv);
		return {18'h0_0000, 1'h1, 3'h0, 1'h1, inv, ts, b, c, m};
	endfunction : cfgv
	task automatic wait_take();
		int k;
		k = 0;
		while (take !== 1'b1 && k < 400) begin
			@(posedge clock_in);
			k++;
		end
		chk(32'(k < 400), 32'h0000_0001, "take");
	endtask : wait_take
	////////////////////////////////////////////////////////////////////
	task automatic send(input logic [2:0] c, input logic inv,
		input logic b);
		logic [5:0] pat;
		logic prev, s, m;
		pat = 6'h26;
		prev = 1'b1;
		req <= 1'b1;
		tbit <= pat[0];
		last <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			wait_take();
			case (c)
				sbalc_pkg::CODE_NRZ: s = pat[i] ^ inv;
				sbalc_pkg::CODE_NRZI: s = pat[i] ? prev : ~prev;
				sbalc_pkg::CODE_FM0: s = ~prev;
				sbalc_pkg::CODE_FM1: s = ~prev;
				default: s = pat[i];
			endcase
			case (c)
				sbalc_pkg::CODE_FM0: m = pat[i] ? s : ~s;
				sbalc_pkg::CODE_FM1: m = pat[i] ? ~s : s;
				sbalc_pkg::CODE_MAN: m = ~s;
				default: m = s;
			endcase
			chk(txd, s, "cell start");
			if (!b && c >= sbalc_pkg::CODE_FM0 && i > 0)
				chk({rxv, rxb}, {1'b1, pat[i - 1]},
					"rx biphase");
			repeat (4) @(posedge clock_in);
			chk(txd, m, "cell middle");
			if (!b && c <= sbalc_pkg::CODE_NRZI)
				chk({rxv, rxb}, {1'b1, pat[i]}, "rx level");
			if (i > 0)
				chk(rts_n, 1'h0, "rts");
			prev = m;
			tbit <= pat[(i + 1) % 6];
			last <= (i == 4);
		end
		if (b)
			repeat (4) @(posedge clock_in);
		req <= 1'b0;
		last <= 1'b0;
		repeat (8) @(posedge clock_in);
	endtask : send
	task automatic s_regs();
		chk(txd, 1'h1, "idle line");
		apb(1'b0, sbalc_pkg::ADDR_CFG, 32'h0000_0000);
		chk(rd, {18'h0_0000, sbalc_pkg::CFG_RST}, "cfg reset");
		apb(1'b0, sbalc_pkg::ADDR_DIV, 32'h0000_0000);
		chk(rd, {16'h0000, sbalc_pkg::DIV_RST}, "div reset");
		apb(1'b1, sbalc_pkg::ADDR_CFG, cfgv(2'h1, 3'h4, 1'h1, 2'h3, 1'h1));
		apb(1'b0, sbalc_pkg::ADDR_CFG, 32'h0000_0000);
		chk(rd, cfgv(2'h1, 3'h4, 1'h1, 2'h3, 1'h1), "cfg back");
		apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
		chk(er, 1'h1, "unmapped error");
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk(rd, 32'h0000_0000, "unmapped data");
	endtask : s_regs
	task automatic s_codes();
		for (int c = 0; c < 6; c++) begin
			apb(1'b1, sbalc_pkg::ADDR_CFG,
				cfgv(2'h0, 3'(c % 5), 1'h0, 2'h1, 1'(c / 5)));
			send(3'(c % 5), 1'(c / 5), 1'b0);
			if (c == 0)
				chk(sync, 1'h0, "no sync in nrz");
		end
		chk(saw_irq, 1'h1, "sync interrupt");
	endtask : s_codes
	task automatic s_bus();
		for (int t = 0; t < 2; t++) begin
			apb(1'b1, sbalc_pkg::ADDR_CFG, cfgv(sbalc_pkg::MODE_HDLC,
				sbalc_pkg::CODE_NRZ, 1'h1,
				t ? sbalc_pkg::TS_MODE2 : sbalc_pkg::TS_MODE1, 1'h0));
			send(sbalc_pkg::CODE_NRZ, 1'b0, 1'b1);
			apb(1'b0, sbalc_pkg::ADDR_STAT, 32'h0000_0000);
			chk(rd[3], 1'h1, "low class");
			repeat (120) @(posedge clock_in);
			apb(1'b0, sbalc_pkg::ADDR_STAT, 32'h0000_0000);
			chk(rd[7:0], 8'hA1, "class restored");
		end
	endtask : s_bus
	task automatic s_coll(input logic [1:0] m, input logic h,
		input logic [2:0] exp);
		logic [2:0] got;
		got = 3'h0;
		apb(1'b1, sbalc_pkg::ADDR_CFG, cfgv(m, sbalc_pkg::CODE_NRZ, 1'h1,
			sbalc_pkg::TS_MODE2, 1'h0));
		held <= h;
		tbit <= 1'b1;
		req <= 1'b1;
		wait_take();
		jam <= 1'b1;
		repeat (120) begin
			@(posedge clock_in);
			got = got | {mrep, qrst, retry};
		end
		chk(got, exp, "abort pulses");
		chk(txd, 1'h1, "line high");
		apb(1'b0, sbalc_pkg::ADDR_STAT, 32'h0000_0000);
		chk(rd[0], 1'h0, "bus busy");
		req <= 1'b0;
		jam <= 1'b0;
		repeat (100) @(posedge clock_in);
	endtask : s_coll
	////////////////////////////////////////////////////////////////////
	initial begin
		rst_n_in = 1'b0;
		{psel, penable, pwrite, req, tbit, last, held, jam} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (6) @(posedge clock_in);
		rst_n_in <= 1'b1;
		s_regs();
		s_codes();
		s_bus();
		s_coll(sbalc_pkg::MODE_HDLC, 1'b1, 3'h1);
		s_coll(sbalc_pkg::MODE_HDLC, 1'b0, 3'h4);
		s_coll(sbalc_pkg::MODE_BISYNC, 1'b1, 3'h6);
		stop_test();
	end
endmodule : sbalc_top_tb_top
`default_nettype wire
